// ### design/lps_map.svh
`ifndef LPS_MAP_SVH
`define LPS_MAP_SVH

// ---------------------------------------------------------------
// target address and register map
// ---------------------------------------------------------------
`define LPS_I2C_ADDR    7'h44
`define LPS_REG_CMD1    8'h00
`define LPS_REG_CMD2    8'h01
`define LPS_REG_DLSB    8'h02
`define LPS_REG_DMSB    8'h03
`define LPS_REG_RST     8'h00
`define LPS_DATA_RST    16'h0000
`define LPS_ZERO8       8'h00

// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define LPS_MODE_CONT   7
`define LPS_KIND_HI     6
`define LPS_KIND_LO     5
`define LPS_CUR_HI      7
`define LPS_CUR_LO      6
`define LPS_FREQ_HI     5
`define LPS_FREQ_LO     4
`define LPS_RES_HI      3
`define LPS_RES_LO      2
`define LPS_RNG_HI      1
`define LPS_RNG_LO      0

// ---------------------------------------------------------------
// field codes and result masks
// ---------------------------------------------------------------
`define LPS_KIND_NONE   2'h0
`define LPS_KIND_PROX   2'h3
`define LPS_FREQ_MOD    2'h3
`define LPS_RES_16      2'h0
`define LPS_RES_12      2'h1
`define LPS_RES_8       2'h2
`define LPS_MASK_16     16'hffff
`define LPS_MASK_12     16'h0fff
`define LPS_MASK_8      16'h00ff
`define LPS_MASK_4      16'h000f
`define LPS_CNT_MAX     16'hffff
`define LPS_BYTE_BITS   4'h8

// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define LPS_CLK_KHZ     50000
`define LPS_OSC_KHZ     725
`define LPS_MOD_KHZ     360
`define LPS_SCL_KHZ     100
`define LPS_OSC_DIV     (`LPS_CLK_KHZ / `LPS_OSC_KHZ)
`define LPS_MOD_HALF    (`LPS_CLK_KHZ / (2 * `LPS_MOD_KHZ))
`define LPS_SCL_QTR     (`LPS_CLK_KHZ / (4 * `LPS_SCL_KHZ))

`endif

// ### design/lps_pkg.sv
`default_nettype none
package lps_pkg;

  typedef enum logic [3:0] {
    SLV_IDLE, SLV_ADDR, SLV_ADDR_ACK, SLV_PTR, SLV_PTR_ACK,
    SLV_WDATA, SLV_WACK, SLV_RDATA, SLV_RACK
  } lps_slv_state_e;

  typedef enum logic [0:0] {HST_IDLE, HST_SYM} lps_host_state_e;

  typedef enum logic [1:0] {SYM_START, SYM_TX, SYM_RX, SYM_STOP} lps_sym_e;

endpackage
`default_nettype wire

// ### design/lps_if.sv
`default_nettype none
interface lps_if;
  logic host_scl_out;
  logic host_scl_oe;
  logic host_sda_out;
  logic host_sda_oe;
  logic dev_sda_out;
  logic dev_sda_oe;
  logic scl;
  logic sda;

  // open-drain wired-and with pull-up
  assign scl = ~(host_scl_oe & ~host_scl_out);
  assign sda = ~((host_sda_oe & ~host_sda_out) |
                 (dev_sda_oe & ~dev_sda_out));

  modport dev (input scl, input sda,
               output dev_sda_out, output dev_sda_oe);
  modport host (input scl, input sda,
                output host_scl_out, output host_scl_oe,
                output host_sda_out, output host_sda_oe);
endinterface
`default_nettype wire

// ### design/lps_dev_end.sv
// Functional notes
// - start powered down, data reads zero
// - one-shot converts once then powers down
// - continuous mode overwrites data each conversion
// - power-down command stops any measurement
// - six modes, any order of switching
// - internal timing counts 2^n oscillator cycles
// - external period between two timing commands
// - external mode reports counted oscillator cycles
// - result unsigned, width equals programmed resolution with internal timing; the external count fills all 16 bits
// - proximity drives LED per second register
// - current codes 0..3 select 100..12.5 mA
// - code 0 DC, code 3 360 kHz square
// - four ranges selected over the bus
// - two command, two read-only data registers
// - command registers persist until rewritten
// - target address 1000100, eighth bit read/write
// - master clocks, frames; receiver acknowledges
// - host may subtract infrared from proximity
// - first register bits 7:5 select mode
// - resolution code maps 16/12/8/4 bits
// - registers at 00h..03h, reset to 00h
`include "lps_map.svh"
`default_nettype none
module lps_dev_end
  import lps_pkg::*;
#(
  parameter int OSC_DIV  = `LPS_OSC_DIV,
  parameter int MOD_HALF = `LPS_MOD_HALF
) (
  input  wire logic        core_clk_in,
  input  wire logic        nrst_in,
  lps_if.dev               lps_bus,
  input  wire logic        ext_timing_in,
  input  wire logic [15:0] sample_in,
  output logic             ir_led_drive_out,
  output logic [1:0]       led_current_select_out,
  output logic [1:0]       range_select_out,
  output logic             meas_active_out
);

  // ---------------------------------------------------------------
  // i2c target
  // ---------------------------------------------------------------
  logic [2:0]     scl_s, next_scl_s;
  logic [2:0]     sda_s, next_sda_s;
  logic           scl_f, next_scl_f;
  logic           sda_f, next_sda_f;
  lps_slv_state_e st, next_st;
  logic [3:0]     bitcnt, next_bitcnt;
  logic [7:0]     shreg, next_shreg;
  logic [7:0]     ptr, next_ptr;
  logic           rw, next_rw;
  logic [7:0]     cmd1, next_cmd1;
  logic [7:0]     cmd2, next_cmd2;
  logic           sda_oe, next_sda_oe;
  logic           sda_lvl, next_sda_lvl;
  logic           cmd1_wr, next_cmd1_wr;
  logic [15:0]    data;
  logic [7:0]     rd_byte;
  logic           scl_new, sda_new, rise, fall, start, stop;

  always_comb begin
    case (ptr)
      `LPS_REG_CMD1: rd_byte = cmd1;
      `LPS_REG_CMD2: rd_byte = cmd2;
      `LPS_REG_DLSB: rd_byte = data[7:0];
      `LPS_REG_DMSB: rd_byte = data[15:8];
      default:       rd_byte = `LPS_ZERO8;
    endcase
  end

  always_comb begin
    next_scl_s   = {scl_s[1:0], lps_bus.scl};
    next_sda_s   = {sda_s[1:0], lps_bus.sda};
    next_st      = st;
    next_bitcnt  = bitcnt;
    next_shreg   = shreg;
    next_ptr     = ptr;
    next_rw      = rw;
    next_cmd1    = cmd1;
    next_cmd2    = cmd2;
    next_sda_oe  = sda_oe;
    next_sda_lvl = 1'b0;
    next_cmd1_wr = 1'b0;
    scl_new      = (scl_s[2] == scl_s[1]) ? scl_s[1] : scl_f;
    sda_new      = (sda_s[2] == sda_s[1]) ? sda_s[1] : sda_f;
    next_scl_f   = scl_new;
    next_sda_f   = sda_new;
    rise         = scl_new & ~scl_f;
    fall         = ~scl_new & scl_f;
    start        = scl_f & scl_new & sda_f & ~sda_new;
    stop         = scl_f & scl_new & ~sda_f & sda_new;
    if (start) begin
      next_st     = SLV_ADDR;
      next_bitcnt = 4'h0;
      next_sda_oe = 1'b0;
    end else if (stop) begin
      next_st     = SLV_IDLE;
      next_sda_oe = 1'b0;
    end else if (rise) begin
      case (st)
        SLV_ADDR, SLV_PTR, SLV_WDATA: begin
          next_shreg  = {shreg[6:0], sda_new};
          next_bitcnt = bitcnt + 4'h1;
        end
        SLV_RDATA: next_bitcnt = bitcnt + 4'h1;
        // master not acknowledging ends the read
        SLV_RACK: if (sda_new) next_st = SLV_IDLE;
        default: ;
      endcase
    end else if (fall) begin
      case (st)
        SLV_ADDR: begin
          if (bitcnt == `LPS_BYTE_BITS) begin
            if (shreg[7:1] == `LPS_I2C_ADDR) begin
              next_st     = SLV_ADDR_ACK;
              next_rw     = shreg[0];
              next_sda_oe = 1'b1;
            end else begin
              next_st     = SLV_IDLE;
            end
          end
        end
        SLV_ADDR_ACK: begin
          next_bitcnt = 4'h0;
          if (rw) begin
            next_shreg  = rd_byte;
            next_sda_oe = ~rd_byte[7];
            next_st     = SLV_RDATA;
          end else begin
            next_sda_oe = 1'b0;
            next_st     = SLV_PTR;
          end
        end
        SLV_PTR: begin
          if (bitcnt == `LPS_BYTE_BITS) begin
            next_ptr    = shreg;
            next_sda_oe = 1'b1;
            next_st     = SLV_PTR_ACK;
          end
        end
        SLV_PTR_ACK, SLV_WACK: begin
          next_sda_oe = 1'b0;
          next_bitcnt = 4'h0;
          next_st     = SLV_WDATA;
        end
        SLV_WDATA: begin
          if (bitcnt == `LPS_BYTE_BITS) begin
            // only a host write changes a command register
            if (ptr == `LPS_REG_CMD1) begin
              // mode field kept, low bits read zero
              next_cmd1 = `LPS_ZERO8;
              next_cmd1[`LPS_MODE_CONT:`LPS_KIND_LO] =
                shreg[`LPS_MODE_CONT:`LPS_KIND_LO];
              next_cmd1_wr = 1'b1;
            end else if (ptr == `LPS_REG_CMD2) begin
              // range written with the second register
              next_cmd2 = shreg;
            end
            next_sda_oe = 1'b1;
            next_ptr    = ptr + 8'h01;
            next_st     = SLV_WACK;
          end
        end
        SLV_RDATA: begin
          if (bitcnt == `LPS_BYTE_BITS) begin
            next_sda_oe = 1'b0;
            next_ptr    = ptr + 8'h01;
            next_st     = SLV_RACK;
          end else begin
            next_shreg  = {shreg[6:0], 1'b0};
            next_sda_oe = ~shreg[6];
          end
        end
        SLV_RACK: begin
          next_bitcnt = 4'h0;
          next_shreg  = rd_byte;
          next_sda_oe = ~rd_byte[7];
          next_st     = SLV_RDATA;
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!nrst_in) begin
      scl_s   <= 3'h7;
      sda_s   <= 3'h7;
      scl_f   <= 1'b1;
      sda_f   <= 1'b1;
      st      <= SLV_IDLE;
      bitcnt  <= 4'h0;
      shreg   <= `LPS_ZERO8;
      ptr     <= `LPS_ZERO8;
      rw      <= 1'b0;
      cmd1    <= `LPS_REG_RST;
      cmd2    <= `LPS_REG_RST;
      sda_oe  <= 1'b0;
      sda_lvl <= 1'b0;
      cmd1_wr <= 1'b0;
    end else begin
      scl_s   <= next_scl_s;
      sda_s   <= next_sda_s;
      scl_f   <= next_scl_f;
      sda_f   <= next_sda_f;
      st      <= next_st;
      bitcnt  <= next_bitcnt;
      shreg   <= next_shreg;
      ptr     <= next_ptr;
      rw      <= next_rw;
      cmd1    <= next_cmd1;
      cmd2    <= next_cmd2;
      sda_oe  <= next_sda_oe;
      sda_lvl <= next_sda_lvl;
      cmd1_wr <= next_cmd1_wr;
    end
  end

  assign lps_bus.dev_sda_oe  = sda_oe;
  assign lps_bus.dev_sda_out = sda_lvl;

  // ---------------------------------------------------------------
  // conversion engine and led driver
  // ---------------------------------------------------------------
  logic [15:0] osc_cnt, next_osc_cnt;
  logic [15:0] cnt, next_cnt;
  logic        active, next_active;
  logic        ext_run, next_ext_run;
  logic [15:0] next_data;
  logic [15:0] mod_cnt, next_mod_cnt;
  logic        mod_ph, next_mod_ph;
  logic        next_led;
  logic [15:0] mask;
  logic [1:0]  kind;
  logic        cont, osc_tick, led_en, modulate;

  always_comb begin
    kind = cmd1[`LPS_KIND_HI:`LPS_KIND_LO];
    cont = cmd1[`LPS_MODE_CONT];
    case (cmd2[`LPS_RES_HI:`LPS_RES_LO])
      `LPS_RES_16: mask = `LPS_MASK_16;
      `LPS_RES_12: mask = `LPS_MASK_12;
      `LPS_RES_8:  mask = `LPS_MASK_8;
      default:     mask = `LPS_MASK_4;
    endcase
    osc_tick     = (osc_cnt == 16'(OSC_DIV - 1));
    next_osc_cnt = osc_tick ? 16'h0000 : osc_cnt + 16'h0001;
    next_cnt     = cnt;
    next_active  = active;
    next_ext_run = ext_run;
    next_data    = data;
    if (cmd1_wr) begin
      if (kind == `LPS_KIND_NONE) begin
        next_active  = 1'b0;
        next_ext_run = 1'b0;
      end else if (ext_timing_in) begin
        if (ext_run) begin
          next_data    = cnt;
          next_active  = cont;
          next_ext_run = cont;
        end else begin
          next_ext_run = 1'b1;
          next_active  = 1'b1;
        end
        next_cnt = 16'h0000;
      end else begin
        // any mode may follow any other
        next_active  = 1'b1;
        next_ext_run = 1'b0;
        next_cnt     = 16'h0000;
      end
    end else if (active && osc_tick) begin
      if (ext_run) begin
        if (cnt != `LPS_CNT_MAX) next_cnt = cnt + 16'h0001;
      end else if (cnt == mask) begin
        next_data   = sample_in & mask;
        next_cnt    = 16'h0000;
        next_active = cont;
      end else begin
        next_cnt = cnt + 16'h0001;
      end
    end
    led_en       = active && (kind == `LPS_KIND_PROX);
    modulate     = (cmd2[`LPS_FREQ_HI:`LPS_FREQ_LO] == `LPS_FREQ_MOD);
    next_mod_cnt = mod_cnt;
    next_mod_ph  = mod_ph;
    if (!led_en || !modulate) begin
      next_mod_cnt = 16'h0000;
      next_mod_ph  = 1'b1;
    end else if (mod_cnt == 16'(MOD_HALF - 1)) begin
      // equal half periods give 50 percent duty
      next_mod_cnt = 16'h0000;
      next_mod_ph  = ~mod_ph;
    end else begin
      next_mod_cnt = mod_cnt + 16'h0001;
    end
    next_led = led_en & (modulate ? mod_ph : 1'b1);
  end

  always_ff @(posedge core_clk_in) begin
    if (!nrst_in) begin
      osc_cnt                <= 16'h0000;
      cnt                    <= 16'h0000;
      active                 <= 1'b0;
      ext_run                <= 1'b0;
      data                   <= `LPS_DATA_RST;
      mod_cnt                <= 16'h0000;
      mod_ph                 <= 1'b1;
      ir_led_drive_out       <= 1'b0;
      led_current_select_out <= 2'h0;
      range_select_out       <= 2'h0;
      meas_active_out        <= 1'b0;
    end else begin
      osc_cnt                <= next_osc_cnt;
      cnt                    <= next_cnt;
      active                 <= next_active;
      ext_run                <= next_ext_run;
      data                   <= next_data;
      mod_cnt                <= next_mod_cnt;
      mod_ph                 <= next_mod_ph;
      ir_led_drive_out       <= next_led;
      // current code passed to the source
      led_current_select_out <= cmd2[`LPS_CUR_HI:`LPS_CUR_LO];
      // range code to the front end
      range_select_out       <= cmd2[`LPS_RNG_HI:`LPS_RNG_LO];
      meas_active_out        <= next_active;
    end
  end

endmodule
`default_nettype wire

// ### design/lps_host_end.sv
`include "lps_map.svh"
`default_nettype none
module lps_host_end
  import lps_pkg::*;
#(
  parameter int SCL_QTR = `LPS_SCL_QTR
) (
  input  wire logic       core_clk_in,
  input  wire logic       nrst_in,
  lps_if.host             lps_bus,
  input  wire logic       cmd_valid_in,
  input  wire logic       cmd_read_in,
  input  wire logic [7:0] cmd_reg_in,
  input  wire logic [7:0] cmd_wdata_in,
  output logic            cmd_ready_out,
  output logic            done_out,
  output logic [7:0]      rd_data_out,
  output logic            ack_err_out
);

  // ---------------------------------------------------------------
  // transfer script
  // ---------------------------------------------------------------
  function automatic lps_sym_e sym_of(input logic [2:0] s,
                                      input logic rd);
    case (s)
      3'h0:    sym_of = SYM_START;
      3'h3:    sym_of = rd ? SYM_START : SYM_TX;
      3'h4:    sym_of = rd ? SYM_TX : SYM_STOP;
      3'h5:    sym_of = rd ? SYM_RX : SYM_STOP;
      3'h6:    sym_of = SYM_STOP;
      default: sym_of = SYM_TX;
    endcase
  endfunction

  function automatic logic [7:0] tx_of(input logic [2:0] s,
                                       input logic [7:0] ra,
                                       input logic [7:0] wd);
    case (s)
      3'h1:    tx_of = {`LPS_I2C_ADDR, 1'b0};
      3'h2:    tx_of = ra;
      3'h3:    tx_of = wd;
      default: tx_of = {`LPS_I2C_ADDR, 1'b1};
    endcase
  endfunction

  // ---------------------------------------------------------------
  // i2c master
  // ---------------------------------------------------------------
  logic [2:0]      sda_s, next_sda_s;
  logic            sda_f, next_sda_f;
  lps_host_state_e st, next_st;
  logic [2:0]      step, next_step;
  logic [1:0]      ph, next_ph;
  logic [15:0]     qcnt, next_qcnt;
  logic [3:0]      bit_i, next_bit_i;
  logic [7:0]      shreg, next_shreg;
  logic            is_read, next_is_read;
  logic [7:0]      ra, next_ra;
  logic [7:0]      wd, next_wd;
  logic [7:0]      rdat, next_rdat;
  logic            aerr, next_aerr;
  logic            scl_oe, next_scl_oe;
  logic            sda_oe, next_sda_oe;
  logic            lvl, next_lvl;
  logic            next_done;
  logic            qtick, adv;
  lps_sym_e        sym;

  always_comb begin
    next_sda_s   = {sda_s[1:0], lps_bus.sda};
    next_sda_f   = (sda_s[2] == sda_s[1]) ? sda_s[1] : sda_f;
    next_st      = st;
    next_step    = step;
    next_ph      = ph;
    next_bit_i   = bit_i;
    next_shreg   = shreg;
    next_is_read = is_read;
    next_ra      = ra;
    next_wd      = wd;
    next_rdat    = rdat;
    next_aerr    = aerr;
    next_scl_oe  = scl_oe;
    next_sda_oe  = sda_oe;
    next_lvl     = 1'b0;
    next_done    = 1'b0;
    adv          = 1'b0;
    sym          = sym_of(step, is_read);
    qtick        = (qcnt == 16'(SCL_QTR - 1));
    next_qcnt    = qtick ? 16'h0000 : qcnt + 16'h0001;
    case (st)
      HST_IDLE: begin
        next_qcnt = 16'h0000;
        if (cmd_valid_in) begin
          next_is_read = cmd_read_in;
          next_ra      = cmd_reg_in;
          next_wd      = cmd_wdata_in;
          next_step    = 3'h0;
          next_ph      = 2'h0;
          next_bit_i   = 4'h0;
          next_aerr    = 1'b0;
          next_st      = HST_SYM;
        end
      end
      HST_SYM: begin
        if (qtick) begin
          next_ph = ph + 2'h1;
          case (sym)
            SYM_START: begin
              case (ph)
                2'h0: begin
                  next_sda_oe = 1'b0;
                  next_scl_oe = 1'b1;
                end
                2'h1: next_scl_oe = 1'b0;
                2'h2: next_sda_oe = 1'b1;
                default: begin
                  next_scl_oe = 1'b1;
                  adv         = 1'b1;
                end
              endcase
            end
            SYM_STOP: begin
              case (ph)
                2'h0: begin
                  next_scl_oe = 1'b1;
                  next_sda_oe = 1'b1;
                end
                2'h1: next_scl_oe = 1'b0;
                2'h2: next_sda_oe = 1'b0;
                default: adv = 1'b1;
              endcase
            end
            default: begin
              case (ph)
                2'h0: begin
                  next_scl_oe = 1'b1;
                  next_sda_oe = (sym == SYM_TX) &&
                                (bit_i != `LPS_BYTE_BITS) && !shreg[7];
                end
                2'h1: next_scl_oe = 1'b0;
                2'h2: begin
                  if (bit_i == `LPS_BYTE_BITS) begin
                    if (sym == SYM_TX) next_aerr = aerr | sda_f;
                  end else if (sym == SYM_RX) begin
                    next_rdat = {rdat[6:0], sda_f};
                  end else begin
                    next_shreg = {shreg[6:0], 1'b0};
                  end
                end
                default: begin
                  next_scl_oe = 1'b1;
                  next_sda_oe = 1'b0;
                  next_bit_i  = bit_i + 4'h1;
                  if (bit_i == `LPS_BYTE_BITS) adv = 1'b1;
                end
              endcase
            end
          endcase
          if (adv) begin
            next_bit_i = 4'h0;
            next_step  = step + 3'h1;
            next_shreg = tx_of(step + 3'h1, ra, wd);
            if (sym == SYM_STOP) begin
              next_st   = HST_IDLE;
              next_done = 1'b1;
            end
          end
        end
      end
      default: next_st = HST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk_in) begin
    if (!nrst_in) begin
      sda_s         <= 3'h7;
      sda_f         <= 1'b1;
      st            <= HST_IDLE;
      step          <= 3'h0;
      ph            <= 2'h0;
      qcnt          <= 16'h0000;
      bit_i         <= 4'h0;
      shreg         <= `LPS_ZERO8;
      is_read       <= 1'b0;
      ra            <= `LPS_ZERO8;
      wd            <= `LPS_ZERO8;
      rdat          <= `LPS_ZERO8;
      aerr          <= 1'b0;
      scl_oe        <= 1'b0;
      sda_oe        <= 1'b0;
      lvl           <= 1'b0;
      cmd_ready_out <= 1'b0;
      done_out      <= 1'b0;
      rd_data_out   <= `LPS_ZERO8;
      ack_err_out   <= 1'b0;
    end else begin
      sda_s         <= next_sda_s;
      sda_f         <= next_sda_f;
      st            <= next_st;
      step          <= next_step;
      ph            <= next_ph;
      qcnt          <= next_qcnt;
      bit_i         <= next_bit_i;
      shreg         <= next_shreg;
      is_read       <= next_is_read;
      ra            <= next_ra;
      wd            <= next_wd;
      rdat          <= next_rdat;
      aerr          <= next_aerr;
      scl_oe        <= next_scl_oe;
      sda_oe        <= next_sda_oe;
      lvl           <= next_lvl;
      cmd_ready_out <= (next_st == HST_IDLE);
      done_out      <= next_done;
      if (next_done) rd_data_out <= rdat;
      if (next_done) ack_err_out <= aerr;
    end
  end

  assign lps_bus.host_scl_oe  = scl_oe;
  assign lps_bus.host_scl_out = lvl;
  assign lps_bus.host_sda_oe  = sda_oe;
  assign lps_bus.host_sda_out = lvl;

endmodule
`default_nettype wire

// ### testbench/lps_link_asserts.sv
`default_nettype none
module lps_link_asserts (
  input wire logic core_clk_in,
  input wire logic nrst_in,
  input wire logic host_scl_out,
  input wire logic host_scl_oe,
  input wire logic host_sda_out,
  input wire logic host_sda_oe,
  input wire logic dev_sda_out,
  input wire logic dev_sda_oe,
  input wire logic scl,
  input wire logic sda
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!nrst_in);
  chk_outs_stay_low: assert property (
    !host_scl_out && !host_sda_out && !dev_sda_out) else $error("out high");
  chk_reset_release: assert property (disable iff (1'b0)
    !nrst_in |=> !host_scl_oe && !host_sda_oe && !dev_sda_oe)
    else $error("oe in reset");
  chk_scl_high_min: assert property ($rose(scl) |-> scl[*6])
    else $error("scl high short");
  chk_scl_low_min: assert property ($fell(scl) |-> !scl[*6])
    else $error("scl low short");
  chk_frame_by_host: assert property (
    scl && $past(scl) && $changed(sda) |-> $changed(host_sda_oe))
    else $error("sda moved in scl high");
  chk_dev_after_fall: assert property (
    $changed(dev_sda_oe) |-> !scl && $past(scl, 8)) else $error("dev edge");
  chk_dev_sda_hold: assert property (
    $rose(dev_sda_oe) |-> dev_sda_oe[*6]) else $error("dev hold");
  chk_host_yields: assert property (
    $rose(dev_sda_oe) |-> !host_sda_oe) else $error("both drive");
endmodule
`default_nettype wire

// ### testbench/tb_top.sv
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk          = 1'b0;
  logic        nrst         = 1'b0;
  logic        valid        = 1'b0;
  logic        rd           = 1'b0;
  logic [7:0]  ra           = 8'h00;
  logic [7:0]  wd           = 8'h00;
  logic [15:0] sample       = 16'ha5c3;
  logic        ext          = 1'b0;
  logic        ready, done, aerr, led, act, prev;
  logic [7:0]  rdat;
  logic [1:0]  cur, rng;
  int          bad_count    = 0;
  int          total_checks = 0;
  int          edges;
  logic [27:0] rows [12]    = '{
    28'h1_00_00_00, 28'h1_02_00_00, 28'h1_03_00_00, 28'h0_01_3d_00,
    28'h1_01_3d_3d, 28'h0_02_ff_00, 28'h1_02_00_00, 28'h0_00_7f_00,
    28'h1_00_00_60, 28'h1_02_00_03, 28'h1_03_00_00, 28'h1_07_00_00};
  lps_if bus ();
  lps_dev_end #(.OSC_DIV(2), .MOD_HALF(2)) lps_dev_end_inst (
    .core_clk_in(clk), .nrst_in(nrst), .lps_bus(bus), .ext_timing_in(ext),
    .sample_in(sample), .ir_led_drive_out(led),
    .led_current_select_out(cur), .range_select_out(rng),
    .meas_active_out(act));
  lps_host_end #(.SCL_QTR(8)) lps_host_end_inst (
    .core_clk_in(clk), .nrst_in(nrst), .lps_bus(bus), .cmd_valid_in(valid),
    .cmd_read_in(rd), .cmd_reg_in(ra), .cmd_wdata_in(wd),
    .cmd_ready_out(ready), .done_out(done), .rd_data_out(rdat),
    .ack_err_out(aerr));
  lps_link_asserts lps_link_asserts_inst (
    .core_clk_in(clk), .nrst_in(nrst), .host_scl_out(bus.host_scl_out),
    .host_scl_oe(bus.host_scl_oe), .host_sda_out(bus.host_sda_out),
    .host_sda_oe(bus.host_sda_oe), .dev_sda_out(bus.dev_sda_out),
    .dev_sda_oe(bus.dev_sda_oe), .scl(bus.scl), .sda(bus.sda));
  initial begin
    forever #10 clk = ~clk;
  end
  task automatic finish_test();
    if (bad_count == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic xfer(input logic r, input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    while (ready !== 1'b1) @(negedge clk);
    valid = 1'b1;
    rd = r;
    ra = a;
    wd = d;
    @(negedge clk);
    valid = 1'b0;
    for (int i = 0; i < 3000 && done !== 1'b1; i++) @(negedge clk);
    check({7'h00, done}, 8'h01);
    check({7'h00, aerr}, 8'h00);
  endtask
  initial begin
    repeat (5) @(negedge clk);
    nrst = 1'b1;
    foreach (rows[i]) begin
      xfer(rows[i][24], rows[i][23:16], rows[i][15:8]);
      if (rows[i][24])
        check(rdat, rows[i][7:0]);
    end
    check({6'h00, act, led}, 8'h00);
    xfer(1'b0, 8'h01, 8'hf9);
    xfer(1'b0, 8'h00, 8'ha0);
    sample = 16'h1234;
    xfer(1'b1, 8'h02, 8'h00);
    check(rdat, 8'h34);
    check({4'h0, cur, rng}, 8'h0d);
    sample = 16'h5678;
    xfer(1'b1, 8'h02, 8'h00);
    check(rdat, 8'h78);
    xfer(1'b0, 8'h00, 8'he0);
    edges = 0;
    prev = led;
    repeat (8) begin
      @(negedge clk);
      if (led !== prev) edges++;
      prev = led;
    end
    check(8'(edges), 8'h04);
    xfer(1'b0, 8'h00, 8'h00);
    check({6'h00, act, led}, 8'h00);
    xfer(1'b1, 8'h01, 8'h00);
    check(rdat, 8'hf9);
    ext = 1'b1;
    xfer(1'b0, 8'h00, 8'h40);
    xfer(1'b0, 8'h00, 8'h40);
    ext = 1'b0;
    check({6'h00, act, led}, 8'h00);
    xfer(1'b1, 8'h03, 8'h00);
    check(rdat, 8'h01);
    nrst = 1'b0;
    repeat (5) @(negedge clk);
    nrst = 1'b1;
    xfer(1'b1, 8'h01, 8'h00);
    check(rdat, 8'h00);
    xfer(1'b1, 8'h03, 8'h00);
    check(rdat, 8'h00);
    finish_test();
  end
  initial begin
    repeat (40000) @(posedge clk);
    bad_count++;
    finish_test();
  end
endmodule
`default_nettype wire
